// file: rtl/ccp_command_port.v
// Monitor-channel command interpreter for the four-channel codec:
// interrupt mask, analog gain byte, transmit/receive gain coefficients.
// Assumes a monitor byte receiver and transmitter on the same clock.
`include "ccp_regs.vh"
`default_nettype none

module ccp_command_port #(
    parameter FRAC = 16
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Downstream monitor bytes
    input wire [7:0] monByte,
    input wire monByteValid,
    input wire monMsgEnd,
    // Upstream monitor bytes
    output reg [7:0] respByte,
    output reg respValid,
    input wire respReady,
    // Debounced signalling and interrupt
    input wire [7:0] sigBits,
    output wire intN,
    // Per-channel filter enable, 1 selects programmed gain
    input wire [3:0] gainFiltEnable,
    // Per-channel analog controls
    output reg [3:0] attenOn,
    output reg [3:0] txBoost,
    output reg [3:0] rxLoss,
    output reg [3:0] digLoopback,
    output reg [23:0] impScaleNum,
    // Per-channel gains, signed fixed point
    output wire [4*(FRAC+4)-1:0] txGainValue,
    output wire [4*(FRAC+4)-1:0] rxGainValue
);

    localparam [2:0] ST_ADDR = 3'd0;
    localparam [2:0] ST_CMD = 3'd1;
    localparam [2:0] ST_WDATA = 3'd2;
    localparam [2:0] ST_RESP = 3'd3;
    localparam [2:0] ST_DRAIN = 3'd4;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [1:0] chan_r;
    reg [7:0] cmd_r;
    reg [3:0] idx_r;
    reg [3:0] respLen_r;
    reg [7:0] hiByte_r;
    reg [7:0] mask_r;
    reg [7:0] analog_r [0:3];
    reg [15:0] txCoef_r [0:3];
    reg [15:0] rxCoef_r [0:3];
    integer i;
    integer j;

    // Byte fed to the response selector
    wire inCmd = (state_r == ST_CMD);
    wire [7:0] selCmd = inCmd ? monByte : cmd_r;
    wire [1:0] selChan = chan_r;
    wire [3:0] selIdx = inCmd ? 4'h0 : idx_r + 4'h1;
    wire isRead = monByte[`CCP_RW_BIT];
    wire [7:0] wrCmd = {cmd_r[7:1], 1'b0};

    function [3:0] respLenOf;
        input [7:0] c;
        begin
            case (c)
                `CCP_CMD_MASK | 8'h01: respLenOf = 4'h1;
                `CCP_CMD_RTD: respLenOf = 4'h1;
                `CCP_CMD_RTD_CLR: respLenOf = 4'h1;
                `CCP_CMD_ANALOG | 8'h01: respLenOf = 4'h1;
                `CCP_CMD_TXGAIN | 8'h01: respLenOf = 4'h2;
                `CCP_CMD_RXGAIN | 8'h01: respLenOf = 4'h2;
                `CCP_CMD_DIAG | 8'h01: respLenOf = `CCP_DIAG_LEN;
                default: respLenOf = 4'h0;
            endcase
        end
    endfunction

    // data bytes only, no command echo
    reg [7:0] respData;
    always @* begin
        respData = 8'h00;
        case (selCmd)
            `CCP_CMD_MASK | 8'h01: respData = mask_r;
            `CCP_CMD_RTD: respData = sigBits;
            `CCP_CMD_RTD_CLR: respData = sigBits;
            `CCP_CMD_ANALOG | 8'h01: respData = analog_r[selChan];
            `CCP_CMD_TXGAIN | 8'h01: begin
                respData = selIdx[0] ? txCoef_r[selChan][7:0] : txCoef_r[selChan][15:8];
            end
            `CCP_CMD_RXGAIN | 8'h01: begin
                respData = selIdx[0] ? rxCoef_r[selChan][7:0] : rxCoef_r[selChan][15:8];
            end
            `CCP_CMD_DIAG | 8'h01: begin
                case (selIdx)
                    4'h0: respData = analog_r[selChan];
                    4'h1: respData = txCoef_r[selChan][15:8];
                    4'h2: respData = txCoef_r[selChan][7:0];
                    4'h3: respData = rxCoef_r[selChan][15:8];
                    4'h4: respData = rxCoef_r[selChan][7:0];
                    4'h5: respData = mask_r;
                    4'h6: respData = sigBits;
                    4'h7: respData = {5'h00, state_r};
                    default: respData = 8'h00;
                endcase
            end
            default: respData = 8'h00;
        endcase
    end

    wire clearReq = inCmd && monByteValid && (monByte == `CCP_CMD_RTD_CLR);
    wire respLast = (idx_r + 4'h1 == respLen_r);
    wire respTake = respValid && respReady;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_ADDR: begin
                if (monByteValid) begin
                    state_nxt = ST_CMD;
                end
            end
            ST_CMD: begin
                if (monByteValid) begin
                    if (!isRead) begin
                        state_nxt = ST_WDATA;
                    end else if (respLenOf(monByte) != 4'h0) begin
                        state_nxt = ST_RESP;
                    end else begin
                        state_nxt = ST_DRAIN;
                    end
                end
            end
            ST_WDATA: begin
                if (monMsgEnd) begin
                    state_nxt = ST_ADDR;
                end
            end
            ST_RESP: begin
                if (respTake && respLast) begin
                    state_nxt = ST_ADDR;
                end
            end
            ST_DRAIN: begin
                if (monMsgEnd) begin
                    state_nxt = ST_ADDR;
                end
            end
            default: state_nxt = ST_ADDR;
        endcase
        if (monMsgEnd && state_r != ST_RESP) begin
            state_nxt = ST_ADDR;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_ADDR;
            chan_r <= 2'h0;
            cmd_r <= 8'h00;
            idx_r <= 4'h0;
            respLen_r <= 4'h0;
            respByte <= 8'h00;
            respValid <= 1'b0;
        end else begin
            state_r <= state_nxt;
            case (state_r)
                ST_ADDR: begin
                    if (monByteValid) begin
                        chan_r <= monByte[`CCP_CHAN_MSB:`CCP_CHAN_LSB];
                    end
                end
                ST_CMD: begin
                    if (monByteValid) begin
                        cmd_r <= monByte;
                        idx_r <= 4'h0;
                        // first byte ready the cycle after
                        if (isRead && respLenOf(monByte) != 4'h0) begin
                            respLen_r <= respLenOf(monByte);
                            respByte <= respData;
                            respValid <= 1'b1;
                        end
                    end
                end
                ST_WDATA: begin
                    if (monByteValid && idx_r != `CCP_MAX_BYTES) begin
                        idx_r <= idx_r + 4'h1;
                    end
                end
                ST_RESP: begin
                    if (respTake) begin
                        if (respLast) begin
                            respValid <= 1'b0;
                        end else begin
                            idx_r <= idx_r + 4'h1;
                            respByte <= respData;
                        end
                    end
                end
                default: begin
                    respValid <= 1'b0;
                end
            endcase
        end
    end

    // Coefficient storage; a gain word updates only on its second byte
    // so the filters never see half of a new coefficient.
    wire wrByte = (state_r == ST_WDATA) && monByteValid && (idx_r != `CCP_MAX_BYTES);
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_r <= `CCP_MASK_RST;
            hiByte_r <= 8'h00;
            for (i = 0; i < 4; i = i + 1) begin
                analog_r[i] <= `CCP_ANALOG_RST;
                txCoef_r[i] <= `CCP_TXGAIN_RST;
                rxCoef_r[i] <= `CCP_RXGAIN_RST;
            end
        end else if (wrByte) begin
            if (idx_r == 4'h0) begin
                hiByte_r <= monByte;
            end
            case (wrCmd)
                `CCP_CMD_MASK: begin
                    if (idx_r == 4'h0) begin
                        mask_r <= monByte;
                    end
                end
                `CCP_CMD_ANALOG: begin
                    if (idx_r == 4'h0) begin
                        analog_r[chan_r] <= monByte;
                    end
                end
                `CCP_CMD_TXGAIN: begin
                    if (idx_r == 4'h1) begin
                        txCoef_r[chan_r] <= {hiByte_r, monByte};
                    end
                end
                `CCP_CMD_RXGAIN: begin
                    if (idx_r == 4'h1) begin
                        rxCoef_r[chan_r] <= {hiByte_r, monByte};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Analog controls decoded per channel
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            attenOn <= 4'hf;
            txBoost <= 4'h0;
            rxLoss <= 4'h0;
            digLoopback <= 4'h0;
            // Code zero after reset means minus 16 steps
            impScaleNum <= 24'hc30c30;
        end else begin
            for (j = 0; j < 4; j = j + 1) begin
                attenOn[j] <= ~analog_r[j][`CCP_AG_ATTEN_DIS];
                txBoost[j] <= analog_r[j][`CCP_AG_TX_BOOST];
                rxLoss[j] <= analog_r[j][`CCP_AG_RX_LOSS];
                digLoopback[j] <= analog_r[j][`CCP_AG_IMP_MSB:`CCP_AG_IMP_LSB] == `CCP_IMP_LOOPBACK;
                // signed step count, code minus 16
                impScaleNum[j*6 +: 6] <= {1'b0, analog_r[j][`CCP_AG_IMP_MSB:`CCP_AG_IMP_LSB]} - `CCP_IMP_OFFSET;
            end
        end
    end

    // fixed defaults unless the filter is enabled
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : chanGain
            wire [15:0] txSel = gainFiltEnable[g] ? txCoef_r[g] : `CCP_TXGAIN_RST;
            wire [15:0] rxSel = gainFiltEnable[g] ? rxCoef_r[g] : `CCP_RXGAIN_RST;
            ccp_csd_gain #(.LEAD_ONE(1), .FRAC(FRAC)) txEval (
                .clk(clk),
                .reset_n(reset_n),
                .coef(txSel),
                .gain_r(txGainValue[g*(FRAC+4) +: FRAC+4])
            );
            ccp_csd_gain #(.LEAD_ONE(0), .FRAC(FRAC)) rxEval (
                .clk(clk),
                .reset_n(reset_n),
                .coef(rxSel),
                .gain_r(rxGainValue[g*(FRAC+4) +: FRAC+4])
            );
        end
    endgenerate

    ccp_sig_irq sigIrq (
        .clk(clk),
        .reset_n(reset_n),
        .sigBits(sigBits),
        .maskBits(mask_r),
        .clearReq(clearReq),
        .intN(intN)
    );

endmodule
`default_nettype wire

// file: rtl/ccp_regs.vh
// Constants for the coefficient command port: command codes, fields,
// reset values and message limits. Included by the command port module only.
`ifndef CCP_REGS_VH
`define CCP_REGS_VH

// Command codes, write form except the read-only signalling codes 4d and 4f; read form sets bit 0
`define CCP_CMD_MASK 8'h6c
`define CCP_CMD_RTD 8'h4d
`define CCP_CMD_RTD_CLR 8'h4f
`define CCP_CMD_ANALOG 8'h50
`define CCP_CMD_TXGAIN 8'h80
`define CCP_CMD_RXGAIN 8'h82
`define CCP_CMD_DIAG 8'hfc
`define CCP_RW_BIT 0

// Address byte: channel select field
`define CCP_CHAN_MSB 1
`define CCP_CHAN_LSB 0

// Analog gain byte fields
`define CCP_AG_ATTEN_DIS 7
`define CCP_AG_TX_BOOST 6
`define CCP_AG_RX_LOSS 5
`define CCP_AG_IMP_MSB 4
`define CCP_AG_IMP_LSB 0
`define CCP_IMP_LOOPBACK 5'h10
`define CCP_IMP_OFFSET 6'h10

// Reset values
`define CCP_MASK_RST 8'hff
`define CCP_ANALOG_RST 8'h00
`define CCP_TXGAIN_RST 16'ha9f0
`define CCP_RXGAIN_RST 16'h23a1

// Message limits
`define CCP_MAX_BYTES 4'he
`define CCP_DIAG_LEN 4'he

`endif

// file: rtl/ccp_csd_gain.v
// Evaluates one 16-bit gain coefficient of four sign/shift pairs
// into a signed fixed-point value. Coefficient is from same clock.
`default_nettype none

module ccp_csd_gain #(
    parameter LEAD_ONE = 1,
    parameter FRAC = 16
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Coefficient in, gain out (FRAC fraction bits)
    input wire [15:0] coef,
    output reg signed [FRAC+3:0] gain_r
);

    localparam W = FRAC + 4;
    localparam [W-1:0] ONE = {{3{1'b0}}, 1'b1, {FRAC{1'b0}}};

    function signed [W-1:0] csdTerm;
        input signed [W-1:0] v;
        input neg;
        input [2:0] sh;
        reg signed [W-1:0] t;
        begin
            t = v >>> sh;
            csdTerm = neg ? -t : t;
        end
    endfunction

    wire signed [W-1:0] p4 = csdTerm(ONE, coef[15], coef[14:12]);
    wire signed [W-1:0] p3 = csdTerm(ONE + p4, coef[11], coef[10:8]);
    wire signed [W-1:0] p2 = csdTerm(ONE + p3, coef[7], coef[6:4]);
    wire signed [W-1:0] p1 = csdTerm(ONE + p2, coef[3], coef[2:0]);
    wire signed [W-1:0] gain_nxt = (LEAD_ONE != 0) ? ONE + p1 : p1;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_r <= {W{1'b0}};
        end else begin
            gain_r <= gain_nxt;
        end
    end

endmodule
`default_nettype wire

// file: rtl/ccp_sig_irq.v
// Change detector and sticky interrupt for the eight debounced
// signalling bits. Bits come from debounce logic on the same clock.
`default_nettype none

module ccp_sig_irq (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Signalling bits and mask
    input wire [7:0] sigBits,
    input wire [7:0] maskBits,
    // Clear request, one-cycle pulse
    input wire clearReq,
    // Interrupt, active low level
    output reg intN
);

    reg [7:0] prev_r;
    reg pend_r;
    reg pend_nxt;
    wire [7:0] change = (sigBits ^ prev_r) & ~maskBits;

    always @* begin
        pend_nxt = pend_r;
        if (clearReq) begin
            pend_nxt = 1'b0;
        end
        if (|change) begin
            pend_nxt = 1'b1;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= 8'h00;
            pend_r <= 1'b0;
            intN <= 1'b1;
        end else begin
            prev_r <= sigBits;
            pend_r <= pend_nxt;
            intN <= ~pend_nxt;
        end
    end

endmodule
`default_nettype wire

// file: test/ccp_command_port_monitor.sv
// Port checker for the coefficient command port, bound to its top.
// Assumes one clock and the asynchronous active-low reset; FRAC of 16.
`default_nettype none
module ccp_command_port_monitor #(
    parameter FRAC = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Downstream bytes
    input wire logic [7:0] monByte,
    input wire logic monByteValid,
    input wire logic monMsgEnd,
    // Upstream bytes
    input wire logic [7:0] respByte,
    input wire logic respValid,
    input wire logic respReady,
    // Signalling and interrupt
    input wire logic [7:0] sigBits,
    input wire logic intN,
    // Channel controls and gains
    input wire logic [3:0] gainFiltEnable,
    input wire logic [3:0] attenOn,
    input wire logic [3:0] txBoost,
    input wire logic [3:0] rxLoss,
    input wire logic [3:0] digLoopback,
    input wire logic [23:0] impScaleNum,
    input wire logic [4*(FRAC+4)-1:0] txGainValue,
    input wire logic [4*(FRAC+4)-1:0] rxGainValue
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence heldResp;
        respValid && !respReady;
    endsequence
    sequence filtOff;
        !gainFiltEnable[1] [*2];
    endsequence
    AST_RESP_HOLD: assert property (heldResp |=> respValid && $stable(respByte))
        else $error("response byte dropped or changed before taken");
    AST_RESP_START: assert property ($rose(respValid) |-> $past(monByteValid))
        else $error("response started without a command byte");
    AST_INT_CLEAR: assert property ($rose(intN) |-> $past(monByteValid && monByte == 8'h4f))
        else $error("interrupt released without clear command");
    AST_INT_STICKY: assert property (!intN && !(monByteValid && monByte == 8'h4f) |=> !intN)
        else $error("interrupt released on its own");
    AST_INT_QUIET: assert property (intN && $stable(sigBits) |=> intN)
        else $error("interrupt without signalling change");
    AST_LOOPBACK: assert property (digLoopback == {impScaleNum[23:18] == 6'h00, impScaleNum[17:12] == 6'h00,
        impScaleNum[11:6] == 6'h00, impScaleNum[5:0] == 6'h00})
        else $error("loopback does not match scaling code");
    AST_ANALOG_RESET: assert property ($rose(reset_n) |-> attenOn == 4'hf && txBoost == 4'h0
        && rxLoss == 4'h0 && digLoopback == 4'h0 && impScaleNum == 24'hc30c30)
        else $error("analog controls not at reset value");
    AST_TX_DEFAULT: assert property ($rose(reset_n) |=> txGainValue == {4{20'h1fec0}})
        else $error("transmit gain not at default after reset");
    AST_RX_DEFAULT: assert property ($rose(reset_n) |=> rxGainValue == {4{20'h05b00}})
        else $error("receive gain not at default after reset");
    AST_FILT_OFF: assert property (filtOff |-> txGainValue[39:20] == 20'h1fec0
        && rxGainValue[39:20] == 20'h05b00)
        else $error("disabled filter does not use fixed default");
endmodule
bind ccp_command_port ccp_command_port_monitor #(.FRAC(FRAC)) mon (
    .clk(clk), .reset_n(reset_n), .monByte(monByte), .monByteValid(monByteValid), .monMsgEnd(monMsgEnd),
    .respByte(respByte), .respValid(respValid), .respReady(respReady), .sigBits(sigBits), .intN(intN),
    .gainFiltEnable(gainFiltEnable), .attenOn(attenOn), .txBoost(txBoost), .rxLoss(rxLoss),
    .digLoopback(digLoopback), .impScaleNum(impScaleNum), .txGainValue(txGainValue),
    .rxGainValue(rxGainValue));
`default_nettype wire

// file: test/ccp_ctrl_model.sv
// Upstream controller model: sends monitor bytes, takes response bytes.
// Assumes the bench calls its tasks; bytes launch 1 ns after an edge.
`default_nettype none
module ccp_ctrl_model (
    // Clock
    input wire logic clk,
    // Downstream bytes
    output logic [7:0] monByte,
    output logic monByteValid,
    output logic monMsgEnd,
    // Upstream bytes
    input wire logic [7:0] respByte,
    input wire logic respValid,
    output logic respReady
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rxd [0:15];
    int slow;
    initial begin
        monByte = 8'h00;
        monByteValid = 1'b0;
        monMsgEnd = 1'b0;
        respReady = 1'b0;
        slow = 0;
    end
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        #1 monByte = b;
        monByteValid = 1'b1;
    endtask
    task automatic idle(input logic endMsg);
        @(posedge clk);
        #1 monByteValid = 1'b0;
        // Released bus never shows the old byte
        monByte = ~monByte;
        monMsgEnd = endMsg;
        if (endMsg) begin
            @(posedge clk);
            #1 monMsgEnd = 1'b0;
        end
    endtask
    // Slow mode withholds ready on two cycles of three
    task automatic read(input int n, output int got);
        int t;
        got = 0;
        t = 0;
        idle(1'b0);
        while (got < n && t < 200) begin
            respReady = (slow == 0) || (t % 3 == 2);
            @(posedge clk);
            if (respValid === 1'b1 && respReady) begin
                rxd[got] = respByte;
                got++;
            end
            t++;
            #1;
        end
        respReady = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: test/ccp_command_port_bench.sv
// Self-checking bench for the coefficient command port.
// Assumes the controller model drives the monitor byte stream.
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module ccp_command_port_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk;
    logic reset_n;
    logic [7:0] sigBits;
    logic [3:0] gainFiltEnable;
    wire [7:0] monByte;
    wire monByteValid;
    wire monMsgEnd;
    wire [7:0] respByte;
    wire respValid;
    wire respReady;
    wire intN;
    wire [3:0] attenOn;
    wire [3:0] txBoost;
    wire [3:0] rxLoss;
    wire [3:0] digLoopback;
    wire [23:0] impScaleNum;
    wire [79:0] txGainValue;
    wire [79:0] rxGainValue;
    logic [7:0] ana [0:3];
    logic [15:0] txc [0:3];
    logic [15:0] rxc [0:3];
    logic [7:0] msk;
    logic [7:0] v;
    logic [15:0] tc;
    logic [15:0] rc;
    logic [3:0] en;
    int err_total;
    int check_count;
    int seed;
    int got;

    ccp_command_port dut (.clk(clk), .reset_n(reset_n), .monByte(monByte), .monByteValid(monByteValid),
        .monMsgEnd(monMsgEnd), .respByte(respByte), .respValid(respValid), .respReady(respReady),
        .sigBits(sigBits), .intN(intN), .gainFiltEnable(gainFiltEnable), .attenOn(attenOn),
        .txBoost(txBoost), .rxLoss(rxLoss), .digLoopback(digLoopback), .impScaleNum(impScaleNum),
        .txGainValue(txGainValue), .rxGainValue(rxGainValue));
    ccp_ctrl_model ctl (.clk(clk), .monByte(monByte), .monByteValid(monByteValid), .monMsgEnd(monMsgEnd),
        .respByte(respByte), .respValid(respValid), .respReady(respReady));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Nested signed power-of-two product, pair 4 innermost
    function automatic real csd(input logic [15:0] c, input logic lead);
        real t;
        t = 1.0;
        for (int k = 3; k >= 0; k--) begin
            t = (c[4*k+3] ? -1.0 : 1.0) * t / (2.0 ** c[4*k +: 3]);
            if (k > 0 || lead) t = t + 1.0;
        end
        return t;
    endfunction
    // Truncation in the design may cost a few low bits
    function automatic logic near(input real e, input logic [19:0] g);
        real d;
        d = e * 65536.0 - $itor($signed(g));
        return !$isunknown(g) && d < 8.0 && d > -8.0;
    endfunction

    task automatic conclude;
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [1:0] ch, input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
        input int n);
        ctl.send({6'h00, ch});
        ctl.send(cmd);
        ctl.send(d0);
        if (n > 1) ctl.send(d1);
        ctl.idle(1'b1);
    endtask
    task automatic rd(input logic [1:0] ch, input logic [7:0] cmd, input int n);
        ctl.slow = $random(seed) & 1;
        ctl.send({6'h00, ch});
        ctl.send(cmd);
        ctl.read(n, got);
        `CHK("byte count", n, got)
        @(negedge clk);
        `CHK("respValid", 1'b0, respValid)
    endtask
    task automatic rdAll(input logic [1:0] ch);
        rd(ch, 8'h6d, 1);
        `CHK("mask", msk, ctl.rxd[0])
        rd(ch, 8'h51, 1);
        `CHK("analog", ana[ch], ctl.rxd[0])
        rd(ch, 8'h81, 2);
        `CHK("txCoef", txc[ch], ({ctl.rxd[0], ctl.rxd[1]}))
        rd(ch, 8'h83, 2);
        `CHK("rxCoef", rxc[ch], ({ctl.rxd[0], ctl.rxd[1]}))
    endtask
    task automatic chkGain(input logic [1:0] ch, input logic [15:0] t, input logic [15:0] r);
        `CHK("txGain", 1'b1, near(csd(t, 1'b1), txGainValue[ch*20 +: 20]))
        `CHK("rxGain", 1'b1, near(csd(r, 1'b0), rxGainValue[ch*20 +: 20]))
    endtask
    task automatic toggle(input int k);
        @(posedge clk);
        #1 sigBits[k] = ~sigBits[k];
        repeat (3) @(posedge clk);
        #1;
    endtask

    initial begin
        err_total = 0;
        check_count = 0;
        seed = 48;
        reset_n = 1'b0;
        sigBits = 8'h00;
        gainFiltEnable = 4'hf;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        msk = 8'hff;
        for (int c = 0; c < 4; c++) begin
            ana[c] = 8'h00;
            txc[c] = 16'ha9f0;
            rxc[c] = 16'h23a1;
            rdAll(c[1:0]);
            chkGain(c[1:0], 16'ha9f0, 16'h23a1);
        end
        for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? 8'h10 : (i == 1) ? 8'h90 : 8'($random(seed));
            ana[i%4] = v;
            wr(i[1:0], 8'h50, v, 8'h00, 1);
            `CHK("attenOn", ~v[7], attenOn[i%4])
            `CHK("txBoost", v[6], txBoost[i%4])
            `CHK("rxLoss", v[5], rxLoss[i%4])
            `CHK("loopback", v[4:0] == 5'h10, digLoopback[i%4])
            `CHK("impScale", ({1'b0, v[4:0]} - 6'h10), impScaleNum[i%4*6 +: 6])
            rdAll(i[1:0]);
        end
        for (int i = 0; i < 8; i++) begin
            tc = 16'($random(seed));
            rc = 16'($random(seed));
            en = 4'($random(seed));
            txc[i%4] = tc;
            rxc[i%4] = rc;
            wr(i[1:0], 8'h80, tc[15:8], tc[7:0], 2);
            wr(i[1:0], 8'h82, rc[15:8], rc[7:0], 2);
            gainFiltEnable = en;
            rdAll(i[1:0]);
            chkGain(i[1:0], en[i%4] ? tc : 16'ha9f0, en[i%4] ? rc : 16'h23a1);
        end
        // Lone first byte must leave the word alone
        wr(2'd0, 8'h80, 8'h55, 8'h00, 1);
        rdAll(2'd0);
        for (int b = 0; b < 8; b++) begin
            msk = ~(8'h01 << b);
            wr(2'd0, 8'h6c, msk, 8'h00, 1);
            rdAll(b[1:0]);
            toggle((b + 1) % 8);
            `CHK("intN masked", 1'b1, intN)
            toggle(b);
            `CHK("intN raised", 1'b0, intN)
            rd(2'd0, 8'h4d, 1);
            `CHK("signalling", sigBits, ctl.rxd[0])
            `CHK("intN held", 1'b0, intN)
            rd(2'd0, 8'h4f, 1);
            `CHK("intN cleared", 1'b1, intN)
        end
        // Unknown read: no answer, bytes dropped until message end
        wr(2'd1, 8'h01, 8'h6c, 8'h00, 1);
        `CHK("respValid", 1'b0, respValid)
        rdAll(2'd1);
        rd(2'd2, 8'hfd, 14);
        `CHK("diag", ({ana[2], txc[2], rxc[2], msk, sigBits}), ({ctl.rxd[0], ctl.rxd[1], ctl.rxd[2],
            ctl.rxd[3], ctl.rxd[4], ctl.rxd[5], ctl.rxd[6]}))
        `CHK("diag pad", 8'h00, ctl.rxd[13])
        conclude;
    end

    initial begin
        #1000000;
        err_total++;
        conclude;
    end
endmodule
`default_nettype wire
